// file: include/serial_pkg.sv
// Constants for the serial mode/status control block.
// Assumes a 100 MHz system clock and a plain register port.
`default_nettype none
package serial_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [2:0] MODE_ADDR = 3'h0;
	localparam logic [2:0] STAT_ADDR = 3'h1;
	localparam logic [2:0] TXD_ADDR = 3'h2;
	localparam logic [2:0] RXD_ADDR = 3'h3;
	localparam logic [2:0] RATE_ADDR = 3'h4;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [15:0] MODE_WMASK = 16'hbbff;
	localparam logic [15:0] STAT_WMASK = 16'hede0;
	// ---------------------------------------------------------------
	// Mode field positions
	// ---------------------------------------------------------------
	localparam int M_EN = 15;
	localparam int M_SIDL = 13;
	localparam int M_IR = 12;
	localparam int M_RTS_PIN_MODE = 11;
	localparam int M_PIN_LO = 8;
	localparam int M_WAKE = 7;
	localparam int M_LOOP = 6;
	localparam int M_ABD = 5;
	localparam int M_RXINV = 4;
	localparam int M_HS = 3;
	localparam int M_FMT_LO = 1;
	localparam int M_STOP = 0;
	// ---------------------------------------------------------------
	// Status field positions
	// ---------------------------------------------------------------
	localparam int S_TXI1 = 15;
	localparam int S_TXPOL = 14;
	localparam int S_TXI0 = 13;
	localparam int S_BRK = 11;
	localparam int S_TXEN = 10;
	localparam int S_RXI_LO = 6;
	localparam int S_ADDR = 5;
	localparam int S_OVR = 1;
	// ---------------------------------------------------------------
	// Encodings and sizes
	// ---------------------------------------------------------------
	localparam logic [1:0] PIN_BCLK = 2'h3;
	localparam logic [1:0] PIN_FLOW = 2'h2;
	localparam logic [1:0] PIN_RTS = 2'h1;
	localparam logic [1:0] FMT_NINE = 2'h3;
	localparam logic [1:0] FMT_ODD = 2'h2;
	localparam logic [1:0] FMT_EVEN = 2'h1;
	localparam logic [1:0] TXI_EMPTY = 2'h2;
	localparam logic [1:0] TXI_DONE = 2'h1;
	localparam logic [1:0] RXI_FULL = 2'h3;
	localparam logic [1:0] RXI_THREE = 2'h2;
	localparam int FIFO_DEPTH = 4;
	localparam logic [2:0] FIFO_FULL = 3'h4;
	localparam logic [2:0] FIFO_THREE = 3'h3;
	localparam logic [3:0] BRK_ZEROS = 4'hc;
	localparam logic [7:0] SYNC_CHAR = 8'h55;
	localparam logic [3:0] TICKS_STD = 4'hf;
	localparam logic [3:0] TICKS_HS = 4'h3;
	// Infrared pulse: 3 of 16 sub-bit ticks
	localparam logic [3:0] IR_PULSE = 4'h3;
endpackage : serial_pkg
`default_nettype wire

// file: core/serial_ctrl.sv
// Mode/status control and transceiver core of an asynchronous serial port.
// Assumes a single 100 MHz clock; serial pins arrive asynchronously.
//
// Behaviour
// R1 - Infrared enable routes pins through codec
// R2 - Enable owns pins; disabled pins go idle
// R3 - Stop-in-idle halts module during idle
// R4 - RTS mode: simplex or flow control
// R5 - Pin-usage field selects owned pins
// R6 - Wake: falling edge interrupts, rising clears
// R7 - Loopback select feeds transmit to receive
// R8 - Auto-rate measures sync char, self-clears
// R9 - Receive polarity selects line idle level
// R10 - High-speed: 4 ticks per bit, else 16
// R11 - Format: nine bit, odd, even, none
// R12 - Stop select: two or one stop
// R13 - Infrared codec only in 16x mode
// R14 - Transmit interrupt condition selection
// R15 - Infrared transmit idle polarity
// R16 - Break: start, twelve zeros, stop
// R17 - Transmit disable aborts and resets buffer
// R18 - Transmit buffer full flag
// R19 - Transmit all-empty flag
// R20 - Receive interrupt condition selection
// R21 - Address detect in nine-bit mode only
// R22 - Overrun sets; clearing flushes receiver
// R23 - Receive data available flag
// R24 - Receiver idle flag
// R25 - Infrared pulse is 3/16 bit
`default_nettype none
module serial_ctrl
	import serial_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic cpu_idle,
	input wire logic serial_in_pin,
	input wire logic clear_send_pin_n,
	output logic serial_out_pin,
	output logic serial_out_oe_n,
	output logic request_send_pin_n,
	output logic request_send_oe_n,
	output logic baud_clk_out,
	output logic baud_clk_oe_n,
	output logic tx_irq,
	output logic rx_irq,
	output logic wake_irq
);
	// ---------------------------------------------------------------
	// Registers and synchronisers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_ABD} rx_state_e;
	logic [15:0] mode_r;
	logic [15:0] stat_r;
	logic [15:0] rate_r;
	logic [1:0] rx_sync_r;
	logic [1:0] cts_sync_r;
	logic [15:0] brg_cnt_r;
	logic tick;
	logic run;
	logic [1:0] pins;
	logic hs;
	logic ir_on;
	logic nine;
	logic line_in;
	logic rx_bit;
	logic tx_line_r;
	logic wr_mode;
	logic wr_stat;
	assign wr_mode = reg_wr && reg_addr == MODE_ADDR;
	assign wr_stat = reg_wr && reg_addr == STAT_ADDR;
	assign pins = mode_r[M_PIN_LO +: 2];
	assign hs = mode_r[M_HS];
	assign ir_on = mode_r[M_IR] && !hs; // see R13
	assign nine = mode_r[M_FMT_LO +: 2] == FMT_NINE;
	assign run = mode_r[M_EN] && !(mode_r[M_SIDL] && cpu_idle); // see R2 see R3

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sync_r <= 2'h3;
			cts_sync_r <= 2'h3;
		end else begin
			rx_sync_r <= {rx_sync_r[0], serial_in_pin};
			cts_sync_r <= {cts_sync_r[0], clear_send_pin_n};
		end
	end

	// ---------------------------------------------------------------
	// Rate generator: one tick per sub-bit clock
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			brg_cnt_r <= 16'h0000;
		end else if (!run || (reg_wr && reg_addr == RATE_ADDR)) begin
			brg_cnt_r <= 16'h0000;
		end else if (brg_cnt_r >= rate_r) begin
			brg_cnt_r <= 16'h0000;
		end else begin
			brg_cnt_r <= brg_cnt_r + 16'h0001;
		end
	end
	assign tick = run && brg_cnt_r >= rate_r;

	// ---------------------------------------------------------------
	// Receive line conditioning
	// ---------------------------------------------------------------
	logic [3:0] ir_rx_cnt_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ir_rx_cnt_r <= 4'h0;
		end else if (tick) begin
			// Stretch an infrared pulse across the bit so a 3/16 pulse reads zero
			if (!line_in) begin
				ir_rx_cnt_r <= TICKS_STD; // see R25
			end else if (ir_rx_cnt_r != 4'h0) begin
				ir_rx_cnt_r <= ir_rx_cnt_r - 4'h1;
			end
		end
	end
	always_comb begin
		if (mode_r[M_LOOP]) begin
			line_in = tx_line_r; // see R7
		end else begin
			line_in = rx_sync_r[1] ^ mode_r[M_RXINV]; // see R9
		end
		if (ir_on && !mode_r[M_LOOP]) begin
			rx_bit = ir_rx_cnt_r == 4'h0; // see R1
		end else begin
			rx_bit = line_in;
		end
	end

	// ---------------------------------------------------------------
	// Transmit buffer and shifter
	// ---------------------------------------------------------------
	logic [8:0] txq_r [FIFO_DEPTH];
	logic [1:0] txq_rd_r;
	logic [1:0] txq_wr_r;
	logic [2:0] txq_cnt_r;
	tx_state_e tx_st_r;
	logic [11:0] tx_sh_r;
	logic [3:0] tx_bits_r;
	logic [3:0] tx_sub_r;
	logic tx_load;
	logic tx_push;
	logic tx_brk_frame_r;
	logic tx_parity;
	logic [3:0] bit_ticks;
	assign bit_ticks = hs ? TICKS_HS : TICKS_STD; // see R10
	assign tx_push = reg_wr && reg_addr == TXD_ADDR && txq_cnt_r != FIFO_FULL;
	assign tx_load = tx_st_r == TX_IDLE && txq_cnt_r != 3'h0 && stat_r[S_TXEN] && tick;
	assign tx_parity = ^txq_r[txq_rd_r][7:0] ^ (mode_r[M_FMT_LO +: 2] == FMT_ODD);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			txq_rd_r <= 2'h0;
			txq_wr_r <= 2'h0;
			txq_cnt_r <= 3'h0;
		end else if (!stat_r[S_TXEN] || !mode_r[M_EN]) begin
			txq_rd_r <= 2'h0; // see R17
			txq_wr_r <= 2'h0;
			txq_cnt_r <= 3'h0;
		end else begin
			if (tx_push) begin
				txq_r[txq_wr_r] <= reg_wdata[8:0];
				txq_wr_r <= txq_wr_r + 2'h1;
			end
			if (tx_load) begin
				txq_rd_r <= txq_rd_r + 2'h1;
			end
			txq_cnt_r <= txq_cnt_r + {2'h0, tx_push} - {2'h0, tx_load};
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_st_r <= TX_IDLE;
			tx_sh_r <= 12'hfff;
			tx_bits_r <= 4'h0;
			tx_sub_r <= 4'h0;
			tx_line_r <= 1'b1;
			tx_brk_frame_r <= 1'b0;
		end else if (!stat_r[S_TXEN] || !run) begin
			tx_st_r <= TX_IDLE; // see R17
			tx_line_r <= 1'b1;
			tx_brk_frame_r <= 1'b0;
		end else begin
			case (tx_st_r)
				TX_IDLE: begin
					if (tx_load) begin
						tx_st_r <= TX_SHIFT;
						tx_sub_r <= 4'h0;
						tx_line_r <= 1'b0;
						tx_brk_frame_r <= stat_r[S_BRK];
						if (stat_r[S_BRK]) begin
							// Payload discarded; twelve zeros then one stop
							tx_sh_r <= 12'h000; // see R16
							tx_bits_r <= BRK_ZEROS + 4'h1;
						end else if (nine) begin
							tx_sh_r <= {3'h7, txq_r[txq_rd_r]}; // see R11
							tx_bits_r <= 4'h9 + {3'h0, mode_r[M_STOP]} + 4'h1; // see R12
						end else if (mode_r[M_FMT_LO +: 2] == 2'h0) begin
							tx_sh_r <= {4'hf, txq_r[txq_rd_r][7:0]};
							tx_bits_r <= 4'h8 + {3'h0, mode_r[M_STOP]} + 4'h1;
						end else begin
							tx_sh_r <= {3'h7, tx_parity, txq_r[txq_rd_r][7:0]};
							tx_bits_r <= 4'h9 + {3'h0, mode_r[M_STOP]} + 4'h1;
						end
					end
				end
				default: begin
					if (tick) begin
						if (tx_sub_r == bit_ticks) begin
							tx_sub_r <= 4'h0;
							if (tx_bits_r == 4'h0) begin
								tx_st_r <= TX_IDLE;
								tx_brk_frame_r <= 1'b0;
							end else begin
								tx_line_r <= tx_bits_r == 4'h1 ? 1'b1 : tx_sh_r[0];
								tx_sh_r <= {1'b1, tx_sh_r[11:1]};
								tx_bits_r <= tx_bits_r - 4'h1;
							end
						end else begin
							tx_sub_r <= tx_sub_r + 4'h1;
						end
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Receive shifter, buffer and rate detection
	// ---------------------------------------------------------------
	logic [8:0] rxq_r [FIFO_DEPTH];
	logic [1:0] rxq_rd_r;
	logic [1:0] rxq_wr_r;
	logic [2:0] rxq_cnt_r;
	rx_state_e rx_st_r;
	logic [9:0] rx_sh_r;
	logic [3:0] rx_bits_r;
	logic [3:0] rx_sub_r;
	logic rx_prev_r;
	logic rx_done;
	logic rx_pop;
	logic rx_flush;
	logic [15:0] abd_cnt_r;
	logic [2:0] abd_edges_r;
	logic abd_done;
	logic [8:0] rx_word;
	assign rx_word = nine ? rx_sh_r[9:1] : (mode_r[M_FMT_LO +: 2] == 2'h0 ? {1'b0, rx_sh_r[9:2]}
		: {1'b0, rx_sh_r[8:1]});
	assign rx_pop = reg_rd && reg_addr == RXD_ADDR && rxq_cnt_r != 3'h0;
	// Overrun clear (1 to 0) empties buffer and shifter
	assign rx_flush = wr_stat && stat_r[S_OVR] && !reg_wdata[S_OVR]; // see R22

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_st_r <= RX_IDLE;
			rx_sh_r <= 10'h000;
			rx_bits_r <= 4'h0;
			rx_sub_r <= 4'h0;
			rx_prev_r <= 1'b1;
			abd_cnt_r <= 16'h0000;
			abd_edges_r <= 3'h0;
		end else if (!run || rx_flush) begin
			rx_st_r <= RX_IDLE;
			rx_prev_r <= 1'b1;
		end else begin
			rx_prev_r <= rx_bit;
			case (rx_st_r)
				RX_IDLE: begin
					if (rx_prev_r && !rx_bit) begin
						rx_st_r <= mode_r[M_ABD] ? RX_ABD : RX_SHIFT; // see R8
						rx_sub_r <= 4'h0;
						abd_cnt_r <= 16'h0000;
						abd_edges_r <= 3'h0;
						rx_bits_r <= (nine ? 4'h9 : 4'h8) +
							{3'h0, mode_r[M_FMT_LO +: 2] == FMT_EVEN ||
							mode_r[M_FMT_LO +: 2] == FMT_ODD} + 4'h1;
					end
				end
				RX_ABD: begin
					// Sync char gives five falling edges; count system clocks over 8 bits
					abd_cnt_r <= abd_cnt_r + 16'h0001;
					if (rx_prev_r && !rx_bit) begin
						abd_edges_r <= abd_edges_r + 3'h1;
					end
					if (abd_done) begin
						rx_st_r <= RX_IDLE;
					end
				end
				default: begin
					if (tick) begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == (bit_ticks >> 1) && rx_bits_r != 4'h0) begin
							rx_sh_r <= {rx_bit, rx_sh_r[9:1]};
							rx_bits_r <= rx_bits_r - 4'h1;
						end
						if (rx_sub_r == bit_ticks) begin
							rx_sub_r <= 4'h0;
							if (rx_bits_r == 4'h0) begin
								rx_st_r <= RX_IDLE;
							end
						end
					end
				end
			endcase
		end
	end
	assign abd_done = rx_st_r == RX_ABD && abd_edges_r == 3'h3 && rx_prev_r && !rx_bit;
	logic rx_store;
	// Address filtering drops data characters in nine-bit mode while detection is armed
	assign rx_store = rx_st_r == RX_SHIFT && tick && rx_sub_r == bit_ticks && rx_bits_r == 4'h0
		&& !(stat_r[S_ADDR] && nine && !rx_word[8]); // see R21
	assign rx_done = rx_store;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxq_rd_r <= 2'h0;
			rxq_wr_r <= 2'h0;
			rxq_cnt_r <= 3'h0;
		end else if (rx_flush) begin
			rxq_rd_r <= 2'h0;
			rxq_wr_r <= 2'h0;
			rxq_cnt_r <= 3'h0;
		end else begin
			if (rx_store && rxq_cnt_r != FIFO_FULL) begin
				rxq_r[rxq_wr_r] <= rx_word;
				rxq_wr_r <= rxq_wr_r + 2'h1;
			end
			if (rx_pop) begin
				rxq_rd_r <= rxq_rd_r + 2'h1;
			end
			rxq_cnt_r <= rxq_cnt_r + {2'h0, rx_store && rxq_cnt_r != FIFO_FULL}
				- {2'h0, rx_pop};
		end
	end

	// ---------------------------------------------------------------
	// Register writes and hardware-cleared bits
	// ---------------------------------------------------------------
	logic wake_fall;
	logic wake_rise;
	logic wake_prev_r;
	assign wake_fall = mode_r[M_WAKE] && wake_prev_r && !line_in;
	assign wake_rise = mode_r[M_WAKE] && !wake_prev_r && line_in;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= MODE_RESET;
			rate_r <= 16'h0000;
			wake_prev_r <= 1'b1;
		end else begin
			wake_prev_r <= line_in;
			if (wr_mode) begin
				mode_r <= reg_wdata & MODE_WMASK;
			end
			if (reg_wr && reg_addr == RATE_ADDR) begin
				rate_r <= reg_wdata;
			end
			if (wake_rise) begin
				mode_r[M_WAKE] <= 1'b0; // see R6
			end
			if (abd_done) begin
				mode_r[M_ABD] <= 1'b0; // see R8
				rate_r <= ((abd_cnt_r + 16'h0001) >> (hs ? 3'h5 : 3'h7)) - 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_r <= STAT_RESET;
		end else begin
			if (wr_stat) begin
				// Overrun can only be cleared by software, never set
				stat_r <= (reg_wdata & STAT_WMASK) | {14'h0000, reg_wdata[S_OVR] & stat_r[S_OVR], 1'b0};
			end
			if (tx_load && tx_brk_frame_r == 1'b0 && stat_r[S_BRK]) begin
				stat_r[S_BRK] <= 1'b1;
			end
			if (tx_st_r == TX_SHIFT && tx_brk_frame_r && tick && tx_sub_r == bit_ticks
				&& tx_bits_r == 4'h0) begin
				stat_r[S_BRK] <= 1'b0; // see R16
			end
			if (rx_store && rxq_cnt_r == FIFO_FULL) begin
				stat_r[S_OVR] <= 1'b1; // see R22
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupts, pins and read-back
	// ---------------------------------------------------------------
	logic [1:0] txi;
	logic [1:0] rxi;
	logic tx_empty_all;
	logic tx_end;
	logic [3:0] ir_tx_cnt_r;
	assign txi = {stat_r[S_TXI1], stat_r[S_TXI0]};
	assign rxi = stat_r[S_RXI_LO +: 2];
	assign tx_empty_all = tx_st_r == TX_IDLE && txq_cnt_r == 3'h0; // see R19
	assign tx_end = tx_st_r == TX_SHIFT && tick && tx_sub_r == bit_ticks && tx_bits_r == 4'h0;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ir_tx_cnt_r <= 4'h0;
		end else if (tick) begin
			ir_tx_cnt_r <= tx_sub_r == 4'h0 ? 4'h0 : ir_tx_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
			wake_irq <= 1'b0;
		end else begin
			case (txi) // see R14
				TXI_EMPTY: tx_irq <= tx_load && txq_cnt_r == 3'h1;
				TXI_DONE: tx_irq <= tx_end && txq_cnt_r == 3'h0;
				2'h0: tx_irq <= tx_load;
				default: tx_irq <= 1'b0;
			endcase
			case (rxi) // see R20
				RXI_FULL: rx_irq <= rx_store && rxq_cnt_r == FIFO_THREE;
				RXI_THREE: rx_irq <= rx_store && rxq_cnt_r == 3'h2;
				default: rx_irq <= rx_store && rxq_cnt_r != FIFO_FULL;
			endcase
			wake_irq <= wake_fall; // see R6
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			serial_out_pin <= 1'b1;
			serial_out_oe_n <= 1'b1;
			request_send_pin_n <= 1'b1;
			request_send_oe_n <= 1'b1;
			baud_clk_out <= 1'b0;
			baud_clk_oe_n <= 1'b1;
		end else begin
			serial_out_oe_n <= !(mode_r[M_EN] && stat_r[S_TXEN]); // see R2 see R17
			if (ir_on) begin
				// Pulse opposite the idle level for zeros; idle level from polarity bit
				serial_out_pin <= (tx_line_r || ir_tx_cnt_r >= IR_PULSE)
					? stat_r[S_TXPOL] : !stat_r[S_TXPOL]; // see R1 see R15 see R25
			end else begin
				serial_out_pin <= mode_r[M_LOOP] ? 1'b1 : tx_line_r;
			end
			request_send_oe_n <= !(mode_r[M_EN] && (pins == PIN_FLOW || pins == PIN_RTS)); // see R5
			if (mode_r[M_RTS_PIN_MODE]) begin
				request_send_pin_n <= tx_empty_all; // see R4
			end else begin
				request_send_pin_n <= rxq_cnt_r == FIFO_FULL;
			end
			baud_clk_oe_n <= !(mode_r[M_EN] && pins == PIN_BCLK); // see R5
			baud_clk_out <= tick ? !baud_clk_out : baud_clk_out;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == MODE_ADDR) begin
				reg_rdata <= mode_r;
			end else if (reg_addr == STAT_ADDR) begin
				reg_rdata <= {stat_r[15:10], txq_cnt_r == FIFO_FULL, tx_empty_all, // see R18 see R19
					stat_r[7:5], rx_st_r == RX_IDLE, 2'h0, stat_r[S_OVR], // see R24
					rxq_cnt_r != 3'h0}; // see R23
			end else if (reg_addr == RXD_ADDR) begin
				reg_rdata <= {7'h00, rxq_r[rxq_rd_r]};
			end else if (reg_addr == RATE_ADDR) begin
				reg_rdata <= rate_r;
			end else begin
				reg_rdata <= 16'h0000;
			end
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
	// Clear-to-send input is synchronised but never gates the transmitter
	logic unused_cts;
	assign unused_cts = cts_sync_r[1] ^ rx_done;
endmodule : serial_ctrl
`default_nettype wire

// file: test/serial_ctrl_chk.sv
// Checker for the serial mode/status control block, bound to its top module.
// Assumes writes act next cycle; outputs lag a few cycles.
`default_nettype none
module serial_ctrl_chk
	import serial_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic cpu_idle,
	input wire logic serial_in_pin,
	input wire logic clear_send_pin_n,
	input wire logic serial_out_pin,
	input wire logic serial_out_oe_n,
	input wire logic request_send_pin_n,
	input wire logic request_send_oe_n,
	input wire logic baud_clk_out,
	input wire logic baud_clk_oe_n,
	input wire logic tx_irq,
	input wire logic rx_irq,
	input wire logic wake_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Shadow of the software-written control bits
	// ----
	logic [15:0] mode_sh_r;
	logic txen_sh_r;
	logic [17:0] cfg;
	logic [1:0] pins;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_sh_r <= 16'h0000;
			txen_sh_r <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == MODE_ADDR) begin
				mode_sh_r <= reg_wdata & MODE_WMASK;
			end
			if (reg_wr && reg_addr == STAT_ADDR) begin
				txen_sh_r <= reg_wdata[S_TXEN];
			end
		end
	end
	// Pin checks wait for a settled setup; the ownership checks also need cpu_idle low
	assign cfg = {mode_sh_r, txen_sh_r, cpu_idle};
	assign pins = mode_sh_r[M_PIN_LO +: 2];
	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	a_tx_pin_owner: assert property ($stable(cfg)[*3] ##0 !cpu_idle |->
		serial_out_oe_n == !(mode_sh_r[M_EN] && txen_sh_r)) else $error("tx pin ownership wrong");
	a_rts_pin_owner: assert property ($stable(cfg)[*3] ##0 !cpu_idle |->
		request_send_oe_n == !(mode_sh_r[M_EN] && (pins == PIN_RTS || pins == PIN_FLOW)))
		else $error("rts pin ownership wrong");
	a_bclk_pin_owner: assert property ($stable(cfg)[*3] ##0 !cpu_idle |->
		baud_clk_oe_n == !(mode_sh_r[M_EN] && pins == PIN_BCLK)) else $error("bclk ownership wrong");
	a_loop_pin_idle: assert property ($stable(cfg)[*3] ##0 mode_sh_r[M_LOOP] |-> serial_out_pin)
		else $error("loop leaks to pin");
	a_mode_read_back: assert property (reg_rd && reg_addr == MODE_ADDR |=>
		(reg_rdata & 16'hbb5f) == ($past(mode_sh_r) & 16'hbb5f)) else $error("mode readback wrong");
	a_read_data_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("stray read data");
	a_full_not_empty: assert property (reg_rd && reg_addr == STAT_ADDR |=>
		!(reg_rdata[9] && reg_rdata[8])) else $error("full and empty");
	a_tx_irq_pulse: assert property ($rose(tx_irq) |=> !tx_irq) else $error("tx irq too long");
	a_wake_gated: assert property (wake_irq |-> $past(mode_sh_r[M_WAKE]))
		else $error("wake irq unarmed");
	c_tx_irq: cover property (tx_irq);
	c_rx_irq: cover property (rx_irq);
	c_wake_irq: cover property (wake_irq);
endmodule : serial_ctrl_chk
bind serial_ctrl serial_ctrl_chk chk_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cpu_idle(cpu_idle), .serial_in_pin(serial_in_pin), .clear_send_pin_n(clear_send_pin_n),
	.serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
	.request_send_pin_n(request_send_pin_n), .request_send_oe_n(request_send_oe_n),
	.baud_clk_out(baud_clk_out), .baud_clk_oe_n(baud_clk_oe_n), .tx_irq(tx_irq),
	.rx_irq(rx_irq), .wake_irq(wake_irq));
`default_nettype wire

// file: test/serial_peer.sv
// Remote serial device: receives frames from the block and sends frames to it.
// Assumes 8 data bits, no parity, one stop bit, line idle high.
`default_nettype none
module serial_peer #(
	parameter int BIT_NS = 160
) (
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q[$];
	realtime low_start;
	int low_ns;
	initial line_out = 1'b1;
	// Sample mid-bit; a long low run (break) is waited out before rearming
	always begin
		logic [7:0] b;
		@(negedge line_in);
		#(BIT_NS * 3 / 2);
		for (int i = 0; i < 8; i++) begin
			b[i] = line_in;
			#(BIT_NS);
		end
		got_q.push_back(b);
		if (line_in !== 1'b1) @(posedge line_in);
	end
	always @(negedge line_in) low_start = $realtime;
	always @(posedge line_in) low_ns = int'($realtime - low_start);
	task automatic send_char(input logic [7:0] data);
		line_out = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			line_out = data[i];
			#(BIT_NS);
		end
		line_out = 1'b1;
		#(BIT_NS * 2);
	endtask : send_char
endmodule : serial_peer
`default_nettype wire

// file: test/test_uart_mode_status_control.sv
// Self-checking bench for the serial mode/status control block.
// Assumes divisor 0: one sub-bit tick per clock, 160 ns per bit.
`default_nettype none
`define CHK(nm, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("mismatch %s exp %0h got %0h", nm, exp, got); \
		end \
	end
module test_uart_mode_status_control;
	import serial_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_NS = 160;
	logic sys_clk = 1'b0, arst_n, reg_wr, reg_rd, cpu_idle, clear_send_pin_n, rx_line, tx_line;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic serial_out_pin, serial_out_oe_n, rts_n, rts_oe_n, bclk, bclk_oe_n, tx_irq, rx_irq, wake_irq;
	int mismatches = 0, checks_done = 0, tx_irqs, rx_irqs, wake_irqs;
	always #5 sys_clk = ~sys_clk;
	// Released pin floats to its pull-up level
	assign tx_line = serial_out_oe_n ? 1'b1 : serial_out_pin;
	serial_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle),
		.serial_in_pin(rx_line), .clear_send_pin_n(clear_send_pin_n), .serial_out_pin(serial_out_pin),
		.serial_out_oe_n(serial_out_oe_n), .request_send_pin_n(rts_n), .request_send_oe_n(rts_oe_n),
		.baud_clk_out(bclk), .baud_clk_oe_n(bclk_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq),
		.wake_irq(wake_irq));
	serial_peer #(.BIT_NS(BIT_NS)) peer (.line_in(tx_line), .line_out(rx_line));
	always @(posedge sys_clk) begin
		if (tx_irq === 1'b1) tx_irqs++;
		if (rx_irq === 1'b1) rx_irqs++;
		if (wake_irq === 1'b1) wake_irqs++;
	end
	// ----
	// Register port tasks
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic expect_reg(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e,
		input string nm);
		logic [15:0] d;
		rd(a, d);
		`CHK(nm, e, d & m)
	endtask : expect_reg
	task automatic wait_bit(input int b, input logic v);
		logic [15:0] d;
		int n;
		n = 0;
		do begin
			rd(STAT_ADDR, d);
			n++;
		end while (d[b] !== v && n < 1000);
		`CHK("wait_status", v, d[b])
	endtask : wait_bit
	task automatic complete_run();
		$display("checks_done %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
	// ----
	// Test sequence
	// ----
	initial begin
		{arst_n, reg_wr, reg_rd, cpu_idle, clear_send_pin_n} = 5'h0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		expect_reg(MODE_ADDR, 16'hffff, 16'h0000, "mode_reset");
		expect_reg(STAT_ADDR, 16'hffff, 16'h0110, "stat_reset");
		expect_reg(3'h7, 16'hffff, 16'h0000, "unmapped");
		wr(MODE_ADDR, 16'h3b5f);
		expect_reg(MODE_ADDR, 16'hffff, 16'h3b5f, "mode_rw");
		for (int u = 0; u < 5; u++) begin
			wr(MODE_ADDR, 16'((u < 4 ? 32'h8000 : 32'h0000) + (u % 4) * 256));
			tick(5);
			`CHK("rts_oe", (u == 1 || u == 2) ? 1'b0 : 1'b1, rts_oe_n)
			`CHK("bclk_oe", (u == 3) ? 1'b0 : 1'b1, bclk_oe_n)
		end
		wr(RATE_ADDR, 16'h0000);
		wr(MODE_ADDR, 16'h8000);
		wr(STAT_ADDR, 16'h0400);
		tick(5);
		`CHK("tx_oe_on", 1'b0, serial_out_oe_n)
		peer.got_q.delete();
		tx_irqs = 0;
		wr(TXD_ADDR, 16'h0011);
		tick(4);
		for (int i = 1; i < 5; i++) wr(TXD_ADDR, 16'(32'h11 + i));
		expect_reg(STAT_ADDR, 16'h0300, 16'h0200, "tx_full");
		wait_bit(8, 1'b1);
		tick(40);
		`CHK("tx_count", 5, peer.got_q.size())
		for (int i = 0; i < 5; i++) `CHK("tx_char", 8'(32'h11 + i), peer.got_q[i])
		`CHK("tx_irq_any", 5, tx_irqs)
		wr(STAT_ADDR, 16'h0000);
		tick(5);
		`CHK("tx_oe_off", 1'b1, serial_out_oe_n)
		rx_irqs = 0;
		fork
			peer.send_char(8'h3c);
			begin
				tick(80);
				expect_reg(STAT_ADDR, 16'h0010, 16'h0000, "rx_busy");
			end
		join
		tick(20);
		expect_reg(STAT_ADDR, 16'h0011, 16'h0011, "rx_avail");
		`CHK("rx_irq_any", 1, rx_irqs)
		expect_reg(RXD_ADDR, 16'h00ff, 16'h003c, "rx_char");
		expect_reg(STAT_ADDR, 16'h0001, 16'h0000, "rx_empty");
		wr(STAT_ADDR, 16'h00c0);
		tick(2);
		rx_irqs = 0;
		for (int i = 0; i < 5; i++) peer.send_char(8'(i));
		tick(40);
		expect_reg(STAT_ADDR, 16'h0003, 16'h0003, "overrun");
		`CHK("rx_irq_full", 1, rx_irqs)
		wr(STAT_ADDR, 16'h0000);
		expect_reg(STAT_ADDR, 16'h0003, 16'h0000, "flushed");
		wr(MODE_ADDR, 16'h8040);
		wr(STAT_ADDR, 16'h0400);
		peer.got_q.delete();
		wr(TXD_ADDR, 16'h005a);
		wait_bit(0, 1'b1);
		expect_reg(RXD_ADDR, 16'h00ff, 16'h005a, "loop_char");
		`CHK("loop_pin", 0, peer.got_q.size())
		wr(MODE_ADDR, 16'h8000);
		wr(STAT_ADDR, 16'h0c00);
		wr(TXD_ADDR, 16'h0000);
		wait_bit(8, 1'b1);
		expect_reg(STAT_ADDR, 16'h0800, 16'h0000, "brk_clear");
		`CHK("brk_low", 13 * BIT_NS, peer.low_ns)
		wr(MODE_ADDR, 16'ha000);
		peer.got_q.delete();
		cpu_idle <= 1'b1;
		wr(TXD_ADDR, 16'h0077);
		tick(300);
		`CHK("idle_halt", 0, peer.got_q.size())
		cpu_idle <= 1'b0;
		tick(400);
		`CHK("idle_resume", 1, peer.got_q.size())
		wr(MODE_ADDR, 16'h8080);
		wake_irqs = 0;
		peer.send_char(8'h00);
		tick(20);
		`CHK("wake_irq", 1, wake_irqs)
		expect_reg(MODE_ADDR, 16'h0080, 16'h0000, "wake_clear");
		wr(MODE_ADDR, 16'h8020);
		peer.send_char(SYNC_CHAR);
		tick(20);
		expect_reg(MODE_ADDR, 16'h0020, 16'h0000, "rate_done");
		expect_reg(RATE_ADDR, 16'hffff, 16'h0000, "rate_value");
		complete_run();
	end
endmodule : test_uart_mode_status_control
`undef CHK
`default_nettype wire
